// ---- src/cpfp_pkg.sv ----
package cpfp_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] OFS_CMD_READ_PTR = 12'h0f8;
  localparam logic [ADDR_W-1:0] OFS_CMD_WRITE_PTR = 12'h0fc;
  localparam logic [ADDR_W-1:0] OFS_DL_GEN_OFFSET = 12'h100;
  localparam logic [ADDR_W-1:0] OFS_CMD_FREE_SPACE = 12'h574;
  // ---------------------------------------------------------------
  // field layouts and reset values
  // ---------------------------------------------------------------
  localparam int PTR_W = 12;
  localparam int DL_W = 13;
  localparam int RING_BYTES = 4096;
  localparam logic [PTR_W-1:0] INSTR_BYTES = 12'h004;
  localparam logic [DL_W-1:0] DL_WORD_BYTES = 13'h0004;
  localparam logic [PTR_W-1:0] PTR_RST = 12'h000;
  localparam logic [DL_W-1:0] DL_RST = 13'h0000;
  localparam logic [PTR_W-1:0] ERR_PTR = 12'hfff;
  localparam logic [PTR_W-1:0] FREE_RST = 12'hffc;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [PTR_W-1:0] addr;
  } cpfp_fetch_t;
endpackage

// ---- src/cpfp_top.sv ----
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// Summary of operation
// - display-list offset register holds a 13-bit byte offset in bits 12..0.
// - generated display-list words are written at the current offset.
// - each emitted display-list word advances the offset by four bytes, unless the host writes the offset in the same cycle.
// - host may write the offset to choose where generation starts.
// - command ring is 4096 bytes, four bytes per instruction.
// - host-writable read pointer advances by four on each command fetch, unless a host write or engine error lands in the same cycle.
// - on an engine error the read pointer is forced to 0xfff.
// - free ring space is reported read-only, resetting to 0xffc.
module cpfp_top (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // avalon-mm slave
  input wire logic [cpfp_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // coprocessor engine side
  output cpfp_pkg::cpfp_fetch_t o_fetch,
  input wire logic i_fetch_done,
  output logic [cpfp_pkg::DL_W-1:0] o_dl_addr,
  input wire logic i_dl_emit,
  input wire logic i_engine_err
);
  import cpfp_pkg::*;

  logic waitreq_ff;
  logic [31:0] rdata_ff;
  logic [PTR_W-1:0] wptr_ff;
  logic [PTR_W-1:0] nxt_wptr;
  logic [PTR_W-1:0] rptr_ff;
  logic [PTR_W-1:0] nxt_rptr;
  logic [DL_W-1:0] dl_ff;
  logic [DL_W-1:0] nxt_dl;
  logic [PTR_W-1:0] free_ff;
  logic valid_ff;
  logic err_ff;
  logic nxt_err;
  logic access;
  logic wr_acc;
  logic [31:0] wmerged;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] apply_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [PTR_W-1:0] ring_free(input logic [PTR_W-1:0] wp,
                                                 input logic [PTR_W-1:0] rp);
    logic [PTR_W-1:0] used;
    used = wp - rp;
    return FREE_RST - used;
  endfunction

  // ---------------------------------------------------------------
  // bus handshake: one wait cycle, then a single acknowledge cycle
  // ---------------------------------------------------------------
  assign access = (i_avs_read | i_avs_write) & ~waitreq_ff;
  assign wr_acc = access & i_avs_write;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      waitreq_ff <= 1'b1;
    end else begin
      waitreq_ff <= ~((i_avs_read | i_avs_write) & waitreq_ff);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if ((i_avs_read | i_avs_write) & waitreq_ff) begin
      unique case (i_avs_address)
        OFS_CMD_READ_PTR: rdata_ff <= {{(32-PTR_W){1'b0}}, rptr_ff};
        OFS_CMD_WRITE_PTR: rdata_ff <= {{(32-PTR_W){1'b0}}, wptr_ff};
        OFS_DL_GEN_OFFSET: rdata_ff <= {{(32-DL_W){1'b0}}, dl_ff};
        OFS_CMD_FREE_SPACE: rdata_ff <= {{(32-PTR_W){1'b0}}, free_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // next pointer values
  // ---------------------------------------------------------------
  always_comb begin
    nxt_wptr = wptr_ff;
    nxt_rptr = rptr_ff;
    nxt_dl = dl_ff;
    nxt_err = err_ff;
    wmerged = 32'h0000_0000;
    if (wr_acc && i_avs_address == OFS_CMD_WRITE_PTR) begin
      wmerged = apply_be({{(32-PTR_W){1'b0}}, wptr_ff}, i_avs_writedata, i_avs_byteenable);
      nxt_wptr = wmerged[PTR_W-1:0];
    end
    // the engine advances the offset; a host write in the same cycle wins
    if (i_dl_emit) begin
      nxt_dl = dl_ff + DL_WORD_BYTES;
    end
    if (wr_acc && i_avs_address == OFS_DL_GEN_OFFSET) begin
      wmerged = apply_be({{(32-DL_W){1'b0}}, dl_ff}, i_avs_writedata, i_avs_byteenable);
      nxt_dl = wmerged[DL_W-1:0];
    end
    if (i_fetch_done && valid_ff) begin
      nxt_rptr = rptr_ff + INSTR_BYTES;
    end
    // error recovery: host rewrites the read pointer and clears the fault
    if (wr_acc && i_avs_address == OFS_CMD_READ_PTR) begin
      wmerged = apply_be({{(32-PTR_W){1'b0}}, rptr_ff}, i_avs_writedata, i_avs_byteenable);
      nxt_rptr = wmerged[PTR_W-1:0];
      nxt_err = 1'b0;
    end
    // an error raised in the same cycle as recovery still stands
    if (i_engine_err) begin
      nxt_rptr = ERR_PTR;
      nxt_err = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // pointer state
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wptr_ff <= PTR_RST;
      dl_ff <= DL_RST;
    end else begin
      wptr_ff <= nxt_wptr;
      dl_ff <= nxt_dl;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rptr_ff <= PTR_RST;
      err_ff <= 1'b0;
    end else begin
      rptr_ff <= nxt_rptr;
      err_ff <= nxt_err;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      free_ff <= FREE_RST;
      valid_ff <= 1'b0;
    end else begin
      free_ff <= ring_free(nxt_wptr, nxt_rptr);
      valid_ff <= (nxt_rptr != nxt_wptr) & ~nxt_err;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_avs_waitrequest = waitreq_ff;
  assign o_avs_readdata = rdata_ff;
  assign o_fetch.valid = valid_ff;
  assign o_fetch.addr = rptr_ff;
  assign o_dl_addr = dl_ff;

endmodule // cpfp_top

// ---- verif/cpfp_checker_assertions.sv ----
`timescale 1ns/1ps
module cpfp_checker
  import cpfp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire cpfp_fetch_t o_fetch,
  input wire logic i_fetch_done,
  input wire logic [DL_W-1:0] o_dl_addr,
  input wire logic i_dl_emit,
  input wire logic i_engine_err
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire hw = i_avs_write && !o_avs_waitrequest;
  wire rd = i_avs_read && !o_avs_waitrequest;
  property p_wait; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest
    ##1 o_avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("bad wait");
  property p_dlrd; rd && i_avs_address == OFS_DL_GEN_OFFSET |-> o_avs_readdata ==
    {19'h0, $past(o_dl_addr)}; endproperty
  a_dlrd: assert property (p_dlrd) else $error("dl read");
  property p_rprd; rd && i_avs_address == OFS_CMD_READ_PTR |-> o_avs_readdata ==
    {20'h0, $past(o_fetch.addr)}; endproperty
  a_rprd: assert property (p_rprd) else $error("ptr read");
  property p_emit; i_dl_emit && !hw |=> o_dl_addr == $past(o_dl_addr) + DL_WORD_BYTES; endproperty
  a_emit: assert property (p_emit) else $error("dl step");
  property p_dlst; !i_dl_emit && !hw |=> $stable(o_dl_addr); endproperty
  a_dlst: assert property (p_dlst) else $error("dl moved");
  property p_fadv; o_fetch.valid && i_fetch_done && !i_engine_err && !hw |=>
    o_fetch.addr == $past(o_fetch.addr) + INSTR_BYTES; endproperty
  a_fadv: assert property (p_fadv) else $error("fetch step");
  property p_err; i_engine_err |=> o_fetch.addr == ERR_PTR && !o_fetch.valid; endproperty
  a_err: assert property (p_err) else $error("error ptr");
  property p_idle; !o_fetch.valid && !i_engine_err && !hw |=> $stable(o_fetch.addr); endproperty
  a_idle: assert property (p_idle) else $error("idle moved");
  cover property (i_dl_emit ##1 i_dl_emit);
  cover property (o_fetch.valid && i_fetch_done);
  cover property (i_engine_err);
endmodule // cpfp_checker
bind cpfp_top cpfp_checker chk_i (.*);

// ---- verif/cpfp_engine_model.sv ----
`timescale 1ns/1ps
module cpfp_engine_model
  import cpfp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire cpfp_fetch_t i_fetch,
  input wire logic i_stall,
  output logic o_fetch_done
);
  // takes a command only while one is offered and the bench lets it run
  always_ff @(posedge i_ref_clk) begin
    o_fetch_done <= !i_rst && i_fetch.valid && !i_stall;
  end
endmodule // cpfp_engine_model

// ---- verif/test_coproc_command_fifo_pointers.sv ----
`timescale 1ns/1ps
module test_coproc_command_fifo_pointers;
  import cpfp_pkg::*;
  logic i_ref_clk = 0, i_rst = 1, i_avs_read = 0, i_avs_write = 0, i_dl_emit = 0;
  logic i_engine_err = 0, stall = 1, i_fetch_done, o_avs_waitrequest;
  logic [ADDR_W-1:0] i_avs_address = '0;
  logic [31:0] i_avs_writedata = '0, o_avs_readdata, q;
  logic [3:0] i_avs_byteenable = 4'hf;
  cpfp_fetch_t o_fetch;
  logic [DL_W-1:0] o_dl_addr, d;
  logic [PTR_W-1:0] w, rp;
  int n_mismatch = 0, tests_run = 0, n;
  cpfp_top dut (.*);
  cpfp_engine_model eng (.i_ref_clk, .i_rst, .i_fetch(o_fetch), .i_stall(stall),
    .o_fetch_done(i_fetch_done));
  initial forever #25 i_ref_clk = ~i_ref_clk;
  function automatic logic [31:0] free_of(logic [11:0] wp, logic [11:0] r);
    return {20'h0, FREE_RST - (wp - r)};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] v);
    i_avs_address <= a;
    i_avs_write <= wr;
    i_avs_read <= !wr;
    i_avs_writedata <= v;
    @(posedge i_ref_clk);
    while (o_avs_waitrequest !== 1'b0) @(posedge i_ref_clk);
    q = o_avs_readdata;
    i_avs_read <= 0;
    i_avs_write <= 0;
    @(posedge i_ref_clk);
  endtask
  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_ref_clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    n = $urandom(32'h0931bd34);
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 0;
    @(posedge i_ref_clk);
    bus(0, OFS_CMD_WRITE_PTR, 0); chk(q, 0);
    bus(0, OFS_DL_GEN_OFFSET, 0); chk(q, 0);
    bus(1, OFS_CMD_FREE_SPACE, 0);
    bus(0, OFS_CMD_FREE_SPACE, 0); chk(q, free_of(0, 0));
    bus(0, 12'h004, 0); chk(q, 0);
    i_engine_err <= 1;
    @(posedge i_ref_clk);
    i_engine_err <= 0;
    bus(0, OFS_CMD_READ_PTR, 0); chk(q, {20'h0, ERR_PTR});
    bus(1, OFS_CMD_WRITE_PTR, 32'hff0); chk(o_fetch.valid, 0);
    bus(1, OFS_CMD_READ_PTR, 32'hff0);
    w = 12'hff0;
    repeat (4) begin
      rp = w;
      stall <= 1;
      w = w + 12'(4 * $urandom_range(1, 8));
      bus(1, OFS_CMD_WRITE_PTR, {20'h0, w});
      bus(0, OFS_CMD_FREE_SPACE, 0); chk(q, free_of(w, rp));
      n = 0;
      while ((o_fetch.valid !== 1'b0 || n < 3) && n < 300) begin
        stall <= 1'($urandom_range(0, 1));
        @(posedge i_ref_clk);
        n++;
      end
      chk(o_fetch.addr, w);
      bus(0, OFS_CMD_READ_PTR, 0); chk(q, {20'h0, w});
      bus(0, OFS_CMD_FREE_SPACE, 0); chk(q, free_of(w, w));
    end
    for (int i = 0; i < 3; i++) begin
      d = i ? 13'($urandom) & 13'h1ffc : 13'h1ffc;
      bus(1, OFS_DL_GEN_OFFSET, {19'h0, d}); chk(o_dl_addr, d);
      n = $urandom_range(1, 5);
      i_dl_emit <= 1;
      repeat (n) @(posedge i_ref_clk);
      i_dl_emit <= 0;
      bus(0, OFS_DL_GEN_OFFSET, 0); chk(q, {19'h0, d + 13'(4 * n)});
    end
    // only the low byte lane of the offset is replaced
    i_avs_byteenable <= 4'h1;
    bus(1, OFS_DL_GEN_OFFSET, 32'hffff_ffac);
    i_avs_byteenable <= 4'hf;
    chk(o_dl_addr, {q[12:8], 8'hac});
    // reset in mid run clears the host-written pointers
    i_rst <= 1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 0;
    @(posedge i_ref_clk);
    bus(0, OFS_CMD_WRITE_PTR, 0);
    chk(q, 0);
    bus(0, OFS_DL_GEN_OFFSET, 0);
    chk(q, 0);
    chk(o_dl_addr, 0);
    chk(o_fetch.valid, 0);
    wrap_up();
  end
endmodule // test_coproc_command_fifo_pointers
